// [pewc_host.v]
// Operation
// - read only with chip and output enable low
// - write needs chip, write low, oe high
// - keep page address bits constant per page
// - next byte load within 100 us
// - when protected, unlock precedes every write; code sends it once per page
// - unlock is three fixed writes, then page
// - issue sequence writes without interruption
// - reset sequence clears protection after tWC
`timescale 1ns/1ps
`default_nettype none
`include "pewc_regs.vh"
module pewc_host #(
    parameter [15:0] UNL_A0 = 16'h5555, // sequence addresses, arbitrary
    parameter [15:0] UNL_A1 = 16'h2AAA,
    parameter [7:0] UNL_D0 = 8'hAA, // sequence data, arbitrary
    parameter [7:0] UNL_D1 = 8'h55,
    parameter [7:0] UNL_D2 = 8'hA0,
    parameter [7:0] RST_D2 = 8'h80,
    parameter [7:0] RST_D5 = 8'h20,
    parameter [31:0] BLC_CYC = `PEWC_BLC_CYC, // byte load limit
    parameter [31:0] TWC_CYC = `PEWC_TWC_CYC // write cycle time
) (
    input wire clk_sys_in, // 50 MHz clock
    input wire sys_rst_in, // async reset, high
    input wire cmd_valid_in, // command request
    input wire [1:0] cmd_op_in, // 0 read 1 write 2 poll 3 sdp reset
    input wire [15:0] cmd_addr_in, // byte address
    input wire [7:0] cmd_data_in, // write data
    input wire cmd_last_in, // last byte of page
    input wire protect_in, // device protection believed set
    output wire cmd_ready_out, // command taken
    output reg rsp_valid_out, // one-cycle answer pulse
    output reg [7:0] rsp_data_out, // read data
    output reg rsp_err_out, // page address mismatch refused, or poll timed out while still busy
    output reg mem_ce_n_out, // chip enable, low
    output reg mem_oe_n_out, // output enable, low
    output reg mem_we_n_out, // write strobe, low
    output reg [15:0] mem_addr_out, // address pins
    output reg [7:0] mem_dq_out, // data drive
    output reg mem_dq_oe_out, // data drive enable, high drives
    input wire [7:0] mem_dq_in // data pins sampled
);
    // ****************************************************************
    // states, one-hot
    // ****************************************************************
    localparam [5:0] S_IDLE = 6'h01; // waiting for command
    localparam [5:0] S_WSTB = 6'h02; // write strobe low
    localparam [5:0] S_WGAP = 6'h04; // strobe high recovery
    localparam [5:0] S_RD = 6'h08; // read access
    localparam [5:0] S_RGAP = 6'h10; // read recovery
    localparam [5:0] S_BUSY = 6'h20; // wait programming done
    localparam [31:0] STB_CYC = `PEWC_STB_CYC;
    localparam [31:0] GAP_CYC = `PEWC_GAP_CYC;
    localparam [31:0] RD_CYC = `PEWC_RD_CYC;
    reg [5:0] state_ff, nxt_state;
    reg [31:0] cnt_ff, nxt_cnt; // phase timer
    reg [31:0] blc_ff, nxt_blc; // time since last falling strobe
    reg [31:0] twc_ff, nxt_twc; // programming timeout
    reg [2:0] seq_ff, nxt_seq; // prefix write index
    reg [2:0] seq_len_ff, nxt_seq_len; // prefix length
    reg page_open_ff, nxt_page_open; // page load in progress
    reg [8:0] page_ff, nxt_page; // page address of open page
    reg [7:0] cnt_byte_ff, nxt_cnt_byte; // bytes in page
    reg last_ff, nxt_last; // page ends after this byte
    reg is_poll_ff, nxt_is_poll; // read belongs to poll
    reg tog_ff, nxt_tog; // last toggle bit
    reg [1:0] op_ff, nxt_op;
    reg [15:0] addr_ff, nxt_addr;
    reg [7:0] data_ff, nxt_data;
    reg [7:0] dq_s1_ff, dq_s2_ff; // pin synchroniser
    reg ce_n_nxt, oe_n_nxt, we_n_nxt, dq_oe_nxt;
    reg [15:0] a_nxt;
    reg [7:0] d_nxt;
    reg rv_nxt, re_nxt;
    reg [7:0] rd_nxt;
    // ****************************************************************
    // prefix write lookup, used for unlock and reset
    // ****************************************************************
    // addresses drive bit fifteen low; the device ignores it anyway
    function [23:0] pewc_seq;
        input [2:0] idx;
        input rst;
        begin
            case (idx)
                3'h0: pewc_seq = {UNL_A0, UNL_D0};
                3'h1: pewc_seq = {UNL_A1, UNL_D1};
                3'h2: pewc_seq = {UNL_A0, rst ? RST_D2 : UNL_D2};
                3'h3: pewc_seq = {UNL_A0, UNL_D0};
                3'h4: pewc_seq = {UNL_A1, UNL_D1};
                default: pewc_seq = {UNL_A0, RST_D5};
            endcase
        end
    endfunction
    wire [23:0] seq_word = pewc_seq(seq_ff, op_ff == 2'h3);
    wire in_seq = seq_ff != seq_len_ff;
    wire same_page =
        cmd_addr_in[`PEWC_PAGE_HI:`PEWC_PAGE_LO] == page_ff;
    // still programming: poll bit inverted or toggle moved since last read
    wire poll_busy =
        (rsp_data_out[`PEWC_POLL_BIT] != data_ff[7]) ||
        (rsp_data_out[`PEWC_TOGGLE_BIT] != tog_ff);
    assign cmd_ready_out = (state_ff == S_IDLE) && !sys_rst_in;
    // ****************************************************************
    // data pin synchroniser
    // ****************************************************************
    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dq_s1_ff <= 8'h00;
            dq_s2_ff <= 8'h00;
        end else begin
            dq_s1_ff <= mem_dq_in;
            dq_s2_ff <= dq_s1_ff;
        end
    end
    // ****************************************************************
    // sequencer
    // ****************************************************************
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + 32'h1;
        // count from the falling strobe, first byte of a page included
        nxt_blc = (page_open_ff || state_ff == S_WSTB) ?
            blc_ff + 32'h1 : 32'h0;
        nxt_twc = twc_ff;
        nxt_seq = seq_ff;
        nxt_seq_len = seq_len_ff;
        nxt_page_open = page_open_ff;
        nxt_page = page_ff;
        nxt_cnt_byte = cnt_byte_ff;
        nxt_last = last_ff;
        nxt_is_poll = is_poll_ff;
        nxt_tog = tog_ff;
        nxt_op = op_ff;
        nxt_addr = addr_ff;
        nxt_data = data_ff;
        ce_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        we_n_nxt = 1'b1;
        dq_oe_nxt = 1'b0;
        a_nxt = mem_addr_out;
        d_nxt = mem_dq_out;
        rv_nxt = 1'b0;
        re_nxt = 1'b0;
        rd_nxt = rsp_data_out;
        // page closes early enough that a byte taken now still falls
        // inside the device's load window after its setup gap
        if (page_open_ff && blc_ff >= BLC_CYC - GAP_CYC - 32'h2) begin
            nxt_page_open = 1'b0;
        end
        case (state_ff)
            S_IDLE: begin
                nxt_cnt = 32'h0;
                if (cmd_valid_in) begin
                    nxt_op = cmd_op_in;
                    nxt_addr = cmd_addr_in;
                    nxt_data = cmd_data_in;
                    nxt_last = cmd_last_in;
                    nxt_seq = 3'h0;
                    nxt_seq_len = 3'h0;
                    nxt_twc = 32'h0; // poll timeout starts fresh
                    if (cmd_op_in == 2'h0 || cmd_op_in == 2'h2) begin
                        // oe and ce low together with we high, so no write can start
                        nxt_is_poll = cmd_op_in == 2'h2;
                        oe_n_nxt = 1'b0;
                        ce_n_nxt = 1'b0;
                        a_nxt = cmd_addr_in;
                        nxt_state = S_RD;
                    end else if (cmd_op_in == 2'h3) begin
                        nxt_seq_len = 3'h6;
                        nxt_state = S_WGAP;
                    end else if (page_open_ff && !same_page) begin
                        rv_nxt = 1'b1;
                        re_nxt = 1'b1;
                    end else begin
                        // unlock only on the first byte of a page
                        if (protect_in && !page_open_ff) begin
                            nxt_seq_len = 3'h3;
                        end
                        nxt_state = S_WGAP;
                    end
                end
            end
            S_WGAP: begin
                // oe high before ce and we go low
                if (cnt_ff >= GAP_CYC - 32'h1) begin
                    nxt_cnt = 32'h0;
                    ce_n_nxt = 1'b0;
                    we_n_nxt = 1'b0;
                    dq_oe_nxt = 1'b1;
                    nxt_blc = 32'h0;
                    if (in_seq) begin
                        a_nxt = {1'b0, seq_word[22:8]};
                        d_nxt = seq_word[7:0];
                    end else begin
                        a_nxt = addr_ff;
                        d_nxt = data_ff;
                    end
                    nxt_state = S_WSTB;
                end
            end
            S_WSTB: begin
                ce_n_nxt = 1'b0;
                we_n_nxt = 1'b0;
                dq_oe_nxt = 1'b1;
                nxt_page_open = page_open_ff;
                // strobe held well above the noise reject width
                if (cnt_ff >= STB_CYC - 32'h1) begin
                    nxt_cnt = 32'h0;
                    we_n_nxt = 1'b1;
                    dq_oe_nxt = 1'b1; // hold data past rising edge
                    if (in_seq) begin
                        nxt_seq = seq_ff + 3'h1;
                        nxt_state = S_WGAP;
                        if (op_ff == 2'h3 && seq_ff == 3'h5) begin
                            nxt_twc = 32'h0;
                            nxt_state = S_BUSY;
                        end
                    end else begin
                        nxt_page_open = !last_ff;
                        nxt_page =
                            addr_ff[`PEWC_PAGE_HI:`PEWC_PAGE_LO];
                        nxt_cnt_byte =
                            page_open_ff ? cnt_byte_ff + 8'h01 : 8'h01;
                        rv_nxt = 1'b1;
                        nxt_state = S_IDLE;
                    end
                end
            end
            S_RD: begin
                oe_n_nxt = 1'b0;
                ce_n_nxt = 1'b0;
                if (cnt_ff >= RD_CYC - 32'h1) begin
                    nxt_cnt = 32'h0;
                    rd_nxt = dq_s2_ff;
                    ce_n_nxt = 1'b1;
                    oe_n_nxt = 1'b1;
                    nxt_state = S_RGAP;
                end
            end
            S_RGAP: begin
                if (cnt_ff >= GAP_CYC - 32'h1) begin
                    nxt_cnt = 32'h0;
                    // remember this toggle bit for the next comparison
                    nxt_tog = rsp_data_out[`PEWC_TOGGLE_BIT];
                    if (op_ff == 2'h3 && !is_poll_ff) begin
                        nxt_state = S_IDLE;
                    end else if (is_poll_ff && poll_busy &&
                        twc_ff < TWC_CYC) begin
                        // still busy: poll again
                        nxt_state = S_RD;
                    end else begin
                        rv_nxt = 1'b1;
                        // error only when time ran out while still busy
                        re_nxt = is_poll_ff && poll_busy;
                        nxt_state = S_IDLE;
                    end
                end
            end
            S_BUSY: begin
                // reset command: wait one write cycle time
                nxt_twc = twc_ff + 32'h1;
                if (twc_ff >= TWC_CYC - 32'h1) begin
                    rv_nxt = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
        if (state_ff == S_RD && cnt_ff == 32'h0) begin
            nxt_twc = is_poll_ff ? twc_ff + RD_CYC + GAP_CYC : 32'h0;
        end
    end
    // ****************************************************************
    // state and pin registers
    // ****************************************************************
    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_ff <= S_IDLE;
            cnt_ff <= 32'h0;
            blc_ff <= 32'h0;
            twc_ff <= 32'h0;
            seq_ff <= 3'h0;
            seq_len_ff <= 3'h0;
            page_open_ff <= 1'b0;
            page_ff <= 9'h000;
            cnt_byte_ff <= 8'h00;
            last_ff <= 1'b0;
            is_poll_ff <= 1'b0;
            tog_ff <= 1'b0;
            op_ff <= 2'h0;
            addr_ff <= 16'h0000;
            data_ff <= 8'h00;
            mem_ce_n_out <= 1'b1;
            mem_oe_n_out <= 1'b1;
            mem_we_n_out <= 1'b1;
            mem_addr_out <= 16'h0000;
            mem_dq_out <= 8'h00;
            mem_dq_oe_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_err_out <= 1'b0;
            rsp_data_out <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            blc_ff <= nxt_blc;
            twc_ff <= nxt_twc;
            seq_ff <= nxt_seq;
            seq_len_ff <= nxt_seq_len;
            page_open_ff <= nxt_page_open;
            page_ff <= nxt_page;
            cnt_byte_ff <= nxt_cnt_byte;
            last_ff <= nxt_last;
            is_poll_ff <= nxt_is_poll;
            tog_ff <= nxt_tog;
            op_ff <= nxt_op;
            addr_ff <= nxt_addr;
            data_ff <= nxt_data;
            mem_ce_n_out <= ce_n_nxt;
            mem_oe_n_out <= oe_n_nxt;
            mem_we_n_out <= we_n_nxt;
            mem_addr_out <= a_nxt;
            mem_dq_out <= d_nxt;
            mem_dq_oe_out <= dq_oe_nxt;
            rsp_valid_out <= rv_nxt;
            rsp_err_out <= re_nxt;
            rsp_data_out <= rd_nxt;
        end
    end
endmodule // pewc_host
`default_nettype wire

// [pewc_host_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module pewc_host_checker (
    input wire logic clk_sys_in, // system clock
    input wire logic sys_rst_in, // async reset, high
    input wire logic cmd_ready_out, // idle flag
    input wire logic rsp_valid_out, // answer pulse
    input wire logic mem_ce_n_out, // chip enable, low
    input wire logic mem_oe_n_out, // output enable, low
    input wire logic mem_we_n_out, // write strobe, low
    input wire logic [15:0] mem_addr_out, // address pins
    input wire logic [7:0] mem_dq_out, // data drive
    input wire logic mem_dq_oe_out // data drive enable
);
    // ****************************************************************
    // pin protocol properties
    // ****************************************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    chk_no_contention: assert property (
        !mem_oe_n_out |-> !mem_dq_oe_out) else $error("bus contention");
    chk_write_oe_high: assert property (
        !mem_we_n_out |-> mem_oe_n_out && !mem_ce_n_out)
        else $error("write strobe without chip enable or with oe low");
    chk_strobe_width: assert property (
        $fell(mem_we_n_out) |-> (!mem_we_n_out)[*5] ##1 mem_we_n_out)
        else $error("write strobe width wrong");
    chk_write_hold: assert property (
        !mem_we_n_out && !$past(mem_we_n_out) |-> mem_dq_oe_out
        && $stable(mem_dq_out) && $stable(mem_addr_out))
        else $error("address or data moved under write strobe");
    chk_gap_before: assert property (
        $fell(mem_we_n_out) |-> $past(mem_we_n_out, 3) && $past(mem_oe_n_out))
        else $error("write strobe without recovery gap");
    chk_read_hold: assert property (
        $fell(mem_oe_n_out) |-> (!mem_oe_n_out && !mem_ce_n_out)[*8])
        else $error("read access cut short");
    chk_read_addr: assert property (
        !mem_oe_n_out && !$past(mem_oe_n_out) |-> $stable(mem_addr_out))
        else $error("address moved during read");
    chk_done_quiet: assert property (
        rsp_valid_out || cmd_ready_out |-> mem_we_n_out && mem_oe_n_out)
        else $error("strobe active at completion");
endmodule // pewc_host_checker
bind pewc_host pewc_host_checker u_pewc_host_checker (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
    .mem_ce_n_out(mem_ce_n_out), .mem_oe_n_out(mem_oe_n_out),
    .mem_we_n_out(mem_we_n_out), .mem_addr_out(mem_addr_out),
    .mem_dq_out(mem_dq_out), .mem_dq_oe_out(mem_dq_oe_out));
`default_nettype wire

// [pewc_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pewc_mem_model #(
    parameter logic [15:0] UNL_A0 = 16'h5555, // arbitrary sequence values
    parameter logic [15:0] UNL_A1 = 16'h2AAA,
    parameter logic [7:0] UNL_D0 = 8'hAA,
    parameter logic [7:0] UNL_D1 = 8'h55,
    parameter logic [7:0] UNL_D2 = 8'hA0,
    parameter logic [7:0] RST_D2 = 8'h80,
    parameter logic [7:0] RST_D5 = 8'h20,
    parameter int BLC_NS = 1000, // shortened byte load limit
    parameter int TWC_NS = 4000 // shortened write cycle
) (
    input wire logic ce_n_in, // chip enable, low
    input wire logic oe_n_in, // output enable, low
    input wire logic we_n_in, // write strobe, low
    input wire logic [15:0] addr_in, // address pins
    input wire logic [7:0] dq_in, // resolved data bus
    output logic [7:0] dq_out, // read data
    output logic dq_oe_out // drives bus when high
);
    // ****************************************************************
    // array and protection state
    // ****************************************************************
    logic [7:0] mem [0:65535];
    logic [15:0] la_ff, lst_a_ff; // latched and last written address
    logic [7:0] lst_d_ff; // last written data, for polling
    logic [2:0] sq_ff; // position in unlock or reset sequence
    logic prot_ff, unl_ff, open_ff, busy_ff, tog_ff, clr_ff;
    realtime t_fall, t_busy;
    int viol;
    wire wr = !ce_n_in && !we_n_in && oe_n_in;
    wire rd = !ce_n_in && !oe_n_in;
    assign dq_oe_out = rd;
    // status bits replace data while programming
    assign dq_out = busy_ff ? {~lst_d_ff[7], tog_ff, lst_d_ff[5:0]}
        : mem[addr_in];
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        {prot_ff, unl_ff, open_ff, busy_ff, tog_ff, clr_ff} = 6'h00;
        sq_ff = 3'h0;
        viol = 0;
    end
    always @(posedge rd) if (busy_ff) tog_ff <= ~tog_ff;
    // address on the later falling edge, data on the earlier rising
    always @(posedge wr) begin
        la_ff = addr_in;
        t_fall = $realtime;
    end
    always @(negedge wr) begin
        if ($realtime - t_fall >= 10 && !busy_ff) take(la_ff, dq_in);
    end
    task automatic take(input logic [15:0] a, input logic [7:0] d);
        logic s0, s1;
        s0 = a[14:0] == UNL_A0[14:0];
        s1 = a[14:0] == UNL_A1[14:0];
        if (s0 && d == UNL_D0 && (sq_ff == 0 || sq_ff == 3)) sq_ff++;
        else if (s1 && d == UNL_D1 && (sq_ff == 1 || sq_ff == 4)) sq_ff++;
        else if (s0 && sq_ff == 2 && d == UNL_D2) begin
            sq_ff = 0;
            prot_ff = 1;
            unl_ff = 1;
        end else if (s0 && sq_ff == 2 && d == RST_D2) sq_ff = 3;
        else if (s0 && sq_ff == 5 && d == RST_D5) begin
            sq_ff = 0;
            busy_ff = 1;
            clr_ff = 1;
            t_busy = $realtime;
        end else begin
            sq_ff = 0;
            if (!prot_ff || unl_ff) begin
                if (open_ff && a[15:7] != lst_a_ff[15:7]) viol++;
                mem[a] = d;
                lst_a_ff = a;
                lst_d_ff = d;
                open_ff = 1;
            end
        end
    endtask
    // page close after load silence, then self-timed programming
    always begin
        #10;
        if (open_ff && $realtime - t_fall >= BLC_NS) begin
            {open_ff, unl_ff, busy_ff} = 3'h1;
            t_busy = $realtime;
        end
        if (busy_ff && $realtime - t_busy >= TWC_NS) begin
            if (clr_ff) prot_ff = 0;
            {busy_ff, clr_ff} = 2'h0;
        end
    end
endmodule // pewc_mem_model
`default_nettype wire

// [pewc_regs.vh]
`ifndef PEWC_REGS_VH
`define PEWC_REGS_VH
// ****************************************************************
// pin timing in system clock cycles (50 MHz, 20 ns)
// ****************************************************************
`define PEWC_CLK_NS 20
// strobe low time, above the noise reject figure
`define PEWC_STB_NS 100
`define PEWC_STB_CYC ((`PEWC_STB_NS + `PEWC_CLK_NS - 1) / `PEWC_CLK_NS)
// recovery between cycles, address and data setup
`define PEWC_GAP_NS 60
`define PEWC_GAP_CYC ((`PEWC_GAP_NS + `PEWC_CLK_NS - 1) / `PEWC_CLK_NS)
// read access time allowance
`define PEWC_RD_NS 260
`define PEWC_RD_CYC ((`PEWC_RD_NS + `PEWC_CLK_NS - 1) / `PEWC_CLK_NS)
// byte load gap limit, longest time so rounded down
`define PEWC_BLC_US 100
`define PEWC_BLC_CYC ((`PEWC_BLC_US * 1000) / `PEWC_CLK_NS)
// write cycle time
`define PEWC_TWC_MS 5
`define PEWC_TWC_CYC ((`PEWC_TWC_MS * 1000000) / `PEWC_CLK_NS)
// page address field
`define PEWC_PAGE_LO 7
`define PEWC_PAGE_HI 15
`define PEWC_POLL_BIT 7
`define PEWC_TOGGLE_BIT 6
`endif

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys_in = 0, sys_rst_in = 1, cmd_valid_in = 0;
    logic cmd_last_in = 0, protect_in = 0;
    logic [1:0] cmd_op_in = 0;
    logic [15:0] cmd_addr_in = 0;
    logic [7:0] cmd_data_in = 0, pat = 0, rd_v, t;
    logic er_v;
    wire cmd_ready_out, rsp_valid_out, rsp_err_out, ce_n, oe_n, we_n;
    wire host_oe, dev_oe;
    wire [7:0] rsp_data_out, host_dq, dev_dq;
    wire [15:0] addr;
    int err_total = 0, total_checks = 0;
    // undriven bus wanders so a stale value cannot pass
    wire [7:0] bus = dev_oe ? dev_dq : host_oe ? host_dq : pat;
    initial forever #10 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) pat <= pat + 8'h3B;
    pewc_host #(.BLC_CYC(50), .TWC_CYC(200)) u_pewc_host (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
        .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
        .cmd_last_in(cmd_last_in), .protect_in(protect_in),
        .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_data_out(rsp_data_out), .rsp_err_out(rsp_err_out),
        .mem_ce_n_out(ce_n), .mem_oe_n_out(oe_n), .mem_we_n_out(we_n),
        .mem_addr_out(addr), .mem_dq_out(host_dq),
        .mem_dq_oe_out(host_oe), .mem_dq_in(bus));
    pewc_mem_model u_pewc_mem_model (.ce_n_in(ce_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .addr_in(addr), .dq_in(bus), .dq_out(dev_dq),
        .dq_oe_out(dev_oe));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task bail(input int n);
        if (n > 6000) begin // hung handshake ends the run
            err_total++;
            end_of_test;
        end
    endtask
    // one command: raise at falling edge while idle, wait for answer
    task cmd(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d,
        input logic last);
        int n;
        n = 0;
        @(negedge clk_sys_in);
        while (cmd_ready_out !== 1'b1) begin
            bail(n++);
            @(negedge clk_sys_in);
        end
        {cmd_op_in, cmd_addr_in, cmd_data_in, cmd_last_in} = {op, a, d, last};
        cmd_valid_in = 1;
        @(negedge clk_sys_in);
        cmd_valid_in = 0;
        while (rsp_valid_out !== 1'b1) begin
            bail(n++);
            @(negedge clk_sys_in);
        end
        rd_v = rsp_data_out;
        er_v = rsp_err_out;
    endtask
    task idle(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task s_byte;
        cmd(2'h1, 16'h0123, 8'h3C, 1);
        check("write err", er_v, 8'h00);
        idle(60);
        cmd(2'h0, 16'h0123, 8'h00, 0);
        check("busy poll bit", rd_v[7], 8'h01);
        t = rd_v[6];
        cmd(2'h0, 16'h0123, 8'h00, 0);
        check("toggle bit", rd_v[6], !t[0]);
        cmd(2'h2, 16'h0123, 8'h3C, 0);
        check("poll err", er_v, 8'h00);
        cmd(2'h0, 16'h0123, 8'h00, 0);
        check("byte read", rd_v, 8'h3C);
    endtask
    task s_page;
        for (int i = 0; i < 128; i++) begin
            cmd(2'h1, 16'h0280 + i, 8'h5A ^ i[7:0], i == 127);
            check("page err", er_v, 8'h00);
            if (i == 64) begin
                cmd(2'h1, 16'h0300, 8'h12, 0);
                check("page refuse", er_v, 8'h01);
            end
        end
        idle(60);
        cmd(2'h2, 16'h02FF, 8'h5A ^ 8'h7F, 0);
        check("page poll", er_v, 8'h00);
        for (int i = 0; i < 128; i++) begin
            cmd(2'h0, 16'h0280 + i, 8'h00, 0);
            check("page read", rd_v, 8'h5A ^ i[7:0]);
        end
        check("page violations", u_pewc_mem_model.viol != 0, 8'h00);
    endtask
    task s_timeout;
        cmd(2'h1, 16'h0400, 8'h11, 0);
        idle(80);
        cmd(2'h0, 16'h0400, 8'h00, 0);
        check("load timeout", rd_v[7], 8'h01);
        cmd(2'h2, 16'h0400, 8'h11, 0);
        cmd(2'h0, 16'h0400, 8'h00, 0);
        check("timeout read", rd_v, 8'h11);
    endtask
    task s_protect;
        protect_in = 1;
        cmd(2'h1, 16'h0500, 8'h77, 0);
        cmd(2'h1, 16'h0501, 8'h78, 1);
        check("prot set", u_pewc_mem_model.prot_ff, 8'h01);
        idle(60);
        cmd(2'h2, 16'h0501, 8'h78, 0);
        cmd(2'h0, 16'h0500, 8'h00, 0);
        check("unlocked page", rd_v, 8'h77);
        cmd(2'h0, 16'h5555, 8'h00, 0);
        check("unlock not stored", rd_v, 8'hFF);
        protect_in = 0;
        cmd(2'h1, 16'h0502, 8'h99, 1);
        idle(60);
        cmd(2'h0, 16'h0502, 8'h00, 0);
        check("write rejected", rd_v, 8'hFF);
        cmd(2'h3, 16'h0000, 8'h00, 0);
        idle(10);
        check("prot cleared", u_pewc_mem_model.prot_ff, 8'h00);
        cmd(2'h1, 16'h0502, 8'h99, 1);
        idle(60);
        cmd(2'h2, 16'h0502, 8'h99, 0);
        cmd(2'h0, 16'h0502, 8'h00, 0);
        check("plain write", rd_v, 8'h99);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        sys_rst_in = 0;
        s_byte;
        s_page;
        s_timeout;
        s_protect;
        end_of_test;
    end
endmodule // tb
`default_nettype wire
